// File: rcpm_checker.sv
// Purpose: port assertions for config latch and power modes
// Assumes: sees only rcpm_top ports
// Notes:   bound in below the module
`timescale 1ns/1ps
module rcpm_checker (
    input wire logic        sys_clk,
    input wire logic        reset,
    input wire logic        intRequest,
    input wire logic        eventXferFail,
    input wire logic [15:0] port0ConfigRegister,
    input wire logic [2:0]  clockConfigField,
    input wire logic [1:0]  segmentAddrSelect,
    input wire logic [1:0]  chipSelectCount,
    input wire logic        writeConfigBit,
    input wire logic        busActiveZero,
    input wire logic        latchStrobeCtlZero,
    input wire logic        cpuStall,
    input wire logic        clkStop,
    input wire logic        idleActive,
    input wire logic        powerdownActive
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    // Wake cause seen in idle, then idle must be gone
    sequence idleWake;
        idleActive && (intRequest || eventXferFail);
    endsequence
    sequence idleGone;
        ##[1:8] !idleActive;
    endsequence
    high_byte_a: assert property (port0ConfigRegister[15:8] == 8'h00)
        else $error("config high byte not zero");
    clk_field_a: assert property (port0ConfigRegister[7:5] == clockConfigField)
        else $error("clock field mismatch");
    seg_cs_a: assert property (port0ConfigRegister[4:1] == {segmentAddrSelect, chipSelectCount})
        else $error("segment or chip select mismatch");
    wr_bit_a: assert property (port0ConfigRegister[0] == writeConfigBit)
        else $error("write config mismatch");
    bus_pair_a: assert property (busActiveZero == latchStrobeCtlZero)
        else $error("bus control bits differ");
    clk_stop_a: assert property (clkStop |-> powerdownActive && cpuStall)
        else $error("clock stopped outside power-down");
    idle_run_a: assert property (idleActive |-> cpuStall && !clkStop)
        else $error("idle with clock stopped or cpu running");
    mode_excl_a: assert property (!(idleActive && powerdownActive))
        else $error("idle and power-down together");
    idle_exit_a: assert property (idleWake |-> idleGone)
        else $error("idle not ended by wake cause");
endmodule

bind rcpm_top rcpm_checker u_chk (.*);

// File: rcpm_fast_int.sv
// Purpose: per-pin fast interrupt level checks for power-down entry and exit
// Assumes: pins already synchronised; edge select two bits per pin
// Notes:   one generate loop, registered outputs
`timescale 1ns/1ps
module rcpm_fast_int #(
    parameter int PINS = 8
) (
    input  wire logic              sys_clk,
    input  wire logic              reset,
    input  wire logic [PINS-1:0]   pinLevel,
    input  wire logic [2*PINS-1:0] edgeSel,
    input  wire logic              snapshot,
    output logic                   allInactive,
    output logic                   anyWake
);
    typedef struct packed {
        logic [PINS-1:0] entryLevel;
        logic            allInactive;
        logic            anyWake;
    } rcpm_fi_t;

    rcpm_fi_t        state_q;
    rcpm_fi_t        state_d;
    logic [PINS-1:0] inactive;
    logic [PINS-1:0] wake;

    // Per pin: 01 high active, 10 low active, 11 any change, 00 ignored
    for (genvar i = 0; i < PINS; i++) begin : g_pin
        always_comb begin
            unique case (edgeSel[2*i+:2])
                2'h1: begin
                    inactive[i] = !pinLevel[i];
                    wake[i]     = pinLevel[i];
                end
                2'h2: begin
                    inactive[i] = pinLevel[i];
                    wake[i]     = !pinLevel[i];
                end
                2'h3: begin
                    inactive[i] = 1'b1;
                    wake[i]     = pinLevel[i] != state_q.entryLevel[i];
                end
                default: begin
                    inactive[i] = 1'b1;
                    wake[i]     = 1'b0;
                end
            endcase
        end
    end

    // Snapshot levels at entry so any-edge pins can see a change
    always_comb begin
        state_d             = state_q;
        state_d.entryLevel  = snapshot ? pinLevel : state_q.entryLevel;
        state_d.allInactive = &inactive;
        state_d.anyWake     = |wake;
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign allInactive = state_q.allInactive;
    assign anyWake     = state_q.anyWake;
endmodule

// File: rcpm_pins_model.sv
// Purpose: board straps and reset circuit seen by the block's pins
// Assumes: straps stable while sampled
// Notes:   reset line rests high through its pull-up
`timescale 1ns/1ps
module rcpm_pins_model (
    input  wire logic        wakeReset,
    input  wire logic [16:0] strap,
    output logic      [15:0] port0Pins,
    output logic             externalAccessPin,
    output logic             resetInputPinN
);
    // Straps; bit 16 is the external access level
    assign port0Pins         = strap[15:0];
    assign externalAccessPin = strap[16];
    assign resetInputPinN    = !wakeReset;
endmodule

// File: rcpm_pkg.sv
// Purpose: shared constants and types for reset config latch and power modes
// Assumes: port 0 is 16 pins, high byte bits 15..8, low byte 7..0
// Notes:   all field positions and sampling masks live here
package rcpm_pkg;

    // Reset type codes from the reset sequencer
    typedef enum logic [2:0] {
        RCPM_RST_NONE,
        RCPM_RST_SOFT,
        RCPM_RST_WDOG,
        RCPM_RST_SHORT,
        RCPM_RST_LONG,
        RCPM_RST_POWER
    } rcpm_rst_t;

    // Pin sampling masks per reset type
    localparam logic [15:0] RCPM_MASK_SWWD  = 16'h1fc0;
    localparam logic [15:0] RCPM_MASK_SHORT = 16'h1fff;
    localparam logic [15:0] RCPM_MASK_FULL  = 16'hffff;
    // Low-byte bits that soft resets clear instead of sampling
    localparam logic [15:0] RCPM_CLR_SWWD   = 16'h003c;

    // Port-0 field positions
    localparam int RCPM_CLK_LSB   = 13;
    localparam int RCPM_SEG_LSB   = 11;
    localparam int RCPM_CS_LSB    = 9;
    localparam int RCPM_WRC_POS   = 8;
    localparam int RCPM_BUS_WIDTH_BITS_LSB  = 6;
    localparam int RCPM_BSL_POS   = 4;
    localparam int RCPM_ADP_POS   = 1;
    localparam int RCPM_EMU_POS   = 0;

    // Bus config zero bit positions
    localparam int RCPM_BC_ACT_POS = 10;
    localparam int RCPM_BC_ALE_POS = 9;
    localparam int RCPM_BC_TYP_LSB = 6;

    // System config bit positions
    localparam int RCPM_SC_PWD_POS  = 5;
    localparam int RCPM_SC_BYTD_POS = 9;
    localparam int RCPM_SC_WRC_POS  = 7;

    // Reset value of the latched port image
    localparam logic [15:0] RCPM_P0_RESET = 16'h0000;

    // Power mode states
    typedef enum logic [2:0] {
        RCPM_RUN,
        RCPM_DRAIN,
        RCPM_IDLE,
        RCPM_PD_PROT,
        RCPM_PD_INTR
    } rcpm_mode_t;

    // Idle and power-down request codes
    localparam logic [1:0] RCPM_REQ_IDLE = 2'h1;
    localparam logic [1:0] RCPM_REQ_PWDN = 2'h2;

endpackage

// File: rcpm_sync.sv
// Purpose: two flip-flop synchroniser for a vector of pin levels
// Assumes: inputs are asynchronous levels
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
module rcpm_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             sys_clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } rcpm_sync_t;

    rcpm_sync_t state_q;
    rcpm_sync_t state_d;

    // Shift one stage per edge
    always_comb begin
        state_d.meta   = din;
        state_d.stable = state_q.meta;
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign dout = state_q.stable;
endmodule

// File: rcpm_top.sv
// Purpose: start-up configuration latch and idle / power-down control
// Assumes: reset sequencer gives type code and end strobe; pins asynchronous
// Notes:   sys_clk keeps running; clkStop tells the clock gate to stop
//
// What this block does
// R01 - Soft and watchdog resets sample P0 bits 12..6, short hardware adds the low byte, long and power-on take all pins.
// R02 - Latched high-byte fields land in the low byte of the port-0 config register, high byte zero.
// R03 - Clock config goes to the clock generator, segment select to port 4, chip-select count to port 6.
// R04 - Bus active and latch strobe bits of bus config zero set only if external access is high; bus type from P0 bits 7..6.
// R05 - Pending external bus actions finish before idle or power-down is entered.
// R06 - Low-power entry is refused when ready is enabled but was not active on the last bus access.
// R07 - Both modes start only from the protected instruction; idle stops the CPU while peripherals run.
// R08 - Any interrupt request ends idle and execution resumes.
// R09 - Event transfers run in idle; a failed one ends idle.
// R10 - Power-down stops the internal clock and holds everything including the watchdog.
// R11 - Protected power-down is chosen when the power-down config bit is clear.
// R12 - Protected power-down is entered only if the NMI pin is low, else execution goes on.
// R13 - Protected power-down ends only by an external reset at the reset input pin.
// R14 - Software should check RAM test patterns across power-down.
// R15 - With the config bit set, interruptible power-down needs all enabled fast pins inactive.
// R16 - Interruptible power-down ends on external reset or an enabled fast pin request.
// R17 - The reset-type code selects the sampling mask applied at sequence end.
`timescale 1ns/1ps
module rcpm_top
    import rcpm_pkg::*;
#(
    parameter int FAST_PINS = 8
) (
    input  wire logic                   sys_clk,
    input  wire logic                   reset,
    // Reset sequencer
    input  wire rcpm_rst_t              resetKind,
    input  wire logic                   resetSeqEnd,
    // Pins
    input  wire logic [15:0]            port0Pins,
    input  wire logic                   externalAccessPin,
    input  wire logic                   nmiPinN,
    input  wire logic                   resetInputPinN,
    input  wire logic [FAST_PINS-1:0]   fastExtIntPin,
    // CPU and bus status
    input  wire logic [1:0]             lowPowerReq,
    input  wire logic                   busPending,
    input  wire logic                   readyEnabled,
    input  wire logic                   readySeenActive,
    input  wire logic                   intRequest,
    input  wire logic                   eventXferFail,
    input  wire logic                   powerdownConfigBit,
    input  wire logic [2*FAST_PINS-1:0] fastEdgeSel,
    // Configuration outputs
    output logic [15:0]                 port0ConfigRegister,
    output logic [2:0]                  clockConfigField,
    output logic [1:0]                  segmentAddrSelect,
    output logic [1:0]                  chipSelectCount,
    output logic                        writeConfigBit,
    output logic                        busActiveZero,
    output logic                        latchStrobeCtlZero,
    output logic [1:0]                  busWidthBits,
    output logic                        byteHighDisable,
    output logic                        writeSignalConfig,
    output logic                        bootloaderSelect,
    output logic                        adaptModeBit,
    output logic                        emulationMode,
    // Mode outputs
    output logic                        cpuStall,
    output logic                        clkStop,
    output logic                        idleActive,
    output logic                        powerdownActive,
    output logic                        lowPowerRefused
);
    typedef struct packed {
        logic [15:0] p0;
        logic        eaLatched;
        rcpm_mode_t  mode;
        logic        pdTarget;
        logic        refused;
        logic        cpuStall;
        logic        clkStop;
        logic        idle;
        logic        pwdn;
        logic        byteDis;
    } rcpm_top_t;

    rcpm_top_t        state_q;
    rcpm_top_t        state_d;
    logic [15:0]      p0Sync;
    logic             eaSync;
    logic             nmiSyncN;
    logic             rstPinSyncN;
    logic [FAST_PINS-1:0] fastSync;
    logic             fastAllInactive;
    logic             fastWake;
    logic [15:0]      sampleMask;
    logic [15:0]      clearMask;
    logic             snapshot;
    logic [15:0]      latchImage;
    logic             wantIdle;
    logic             wantPwdn;
    logic             readyBlock;
    logic             nmiAllows;
    logic             pdAllowed;
    logic             wakeIdle;
    logic             wakeProt;
    logic             wakeIntr;

    // Every pin crosses two flops before use
    rcpm_sync #(.WIDTH(19 + FAST_PINS)) u_sync (
        .sys_clk (sys_clk),
        .reset   (reset),
        .din     ({port0Pins, externalAccessPin, nmiPinN, resetInputPinN,
                   fastExtIntPin}),
        .dout    ({p0Sync, eaSync, nmiSyncN, rstPinSyncN, fastSync})
    );

    // Fast external interrupt pins: entry levels and wake requests
    // Adds one register stage after the synchroniser, so entry
    // decisions see a pin about three edges after it moves
    rcpm_fast_int #(
        .PINS (FAST_PINS)
    ) u_fast (
        .sys_clk     (sys_clk),
        .reset       (reset),
        .pinLevel    (fastSync),
        .edgeSel     (fastEdgeSel),
        .snapshot    (snapshot),
        .allInactive (fastAllInactive),
        .anyWake     (fastWake)
    );

    // Sampling and clearing masks per reset kind
    // An unknown or idle code samples no port-0 pin, so a stray end
    // strobe keeps the port image but still relatches external access
    always_comb begin
        sampleMask = 16'h0000;
        clearMask  = 16'h0000;
        unique case (resetKind)
            RCPM_RST_SOFT,
            RCPM_RST_WDOG: begin
                sampleMask = RCPM_MASK_SWWD; // R01
                clearMask  = RCPM_CLR_SWWD;  // R01
            end
            RCPM_RST_SHORT: begin
                sampleMask = RCPM_MASK_SHORT; // R01
            end
            RCPM_RST_LONG,
            RCPM_RST_POWER: begin
                sampleMask = RCPM_MASK_FULL; // R01
            end
            default: begin
                sampleMask = 16'h0000;
                clearMask  = 16'h0000;
            end
        endcase
    end

    // Latch image: keep unsampled bits, clear the soft range,
    // take the sampled pins. Soft kinds leave the clock options
    // alone, so a watchdog reset cannot retune the clock
    assign latchImage = (state_q.p0 & ~sampleMask & ~clearMask)
                      | (p0Sync & sampleMask); // R17

    // Request decode; reserved codes are ignored
    assign wantIdle = (lowPowerReq == RCPM_REQ_IDLE); // R07
    assign wantPwdn = (lowPowerReq == RCPM_REQ_PWDN); // R07

    // Ready left inactive on the last access blocks both modes
    assign readyBlock = readyEnabled && !readySeenActive; // R06

    // Protected variant only from within the NMI routine
    assign nmiAllows = !nmiSyncN; // R12

    // Entry condition of the selected power-down variant
    assign pdAllowed = powerdownConfigBit ? fastAllInactive // R15
                                          : nmiAllows;      // R11

    // Exit conditions per mode
    assign wakeIdle = intRequest || eventXferFail; // R08 R09
    assign wakeProt = !rstPinSyncN;                // R13
    assign wakeIntr = !rstPinSyncN || fastWake;    // R16

    // Entry levels follow the pins while draining, so any-change
    // pins compare against the level seen just before entry
    assign snapshot = (state_q.mode == RCPM_DRAIN);

    // Next state: config latch and low-power mode machine
    always_comb begin
        state_d         = state_q;
        state_d.refused = 1'b0;
        // Config latch at the end of a reset sequence
        if (resetSeqEnd) begin
            state_d.p0        = latchImage;                // R01
            state_d.eaLatched = eaSync;                    // R04
            state_d.byteDis   = !latchImage[RCPM_WRC_POS];
        end
        unique case (state_q.mode)
            RCPM_RUN: begin
                // Only the protected instructions start a mode
                if (wantIdle || wantPwdn) begin
                    state_d.mode     = RCPM_DRAIN; // R07
                    state_d.pdTarget = wantPwdn;
                end
            end
            RCPM_DRAIN: begin
                // Wait for the external bus to go quiet first
                if (busPending) begin
                    state_d.mode = RCPM_DRAIN; // R05
                end else if (readyBlock) begin
                    state_d.mode    = RCPM_RUN; // R06
                    state_d.refused = 1'b1;
                end else if (!state_q.pdTarget) begin
                    state_d.mode = RCPM_IDLE; // R07
                end else if (!pdAllowed) begin
                    // Refused entry: execution simply goes on
                    state_d.mode    = RCPM_RUN; // R12 R15
                    state_d.refused = 1'b1;
                end else if (powerdownConfigBit) begin
                    state_d.mode = RCPM_PD_INTR; // R15
                end else begin
                    state_d.mode = RCPM_PD_PROT; // R11
                end
            end
            RCPM_IDLE: begin
                // Event transfers keep idle; failures end it
                if (wakeIdle) begin
                    state_d.mode = RCPM_RUN; // R08 R09
                end
            end
            RCPM_PD_PROT: begin
                // Interrupts are ignored here, only the pin counts
                if (wakeProt) begin
                    state_d.mode = RCPM_RUN; // R13
                end
            end
            RCPM_PD_INTR: begin
                if (wakeIntr) begin
                    state_d.mode = RCPM_RUN; // R16
                end
            end
            default: begin
                state_d.mode = RCPM_RUN;
            end
        endcase
        // CPU halts outside run; the clock only stops in power-down
        state_d.cpuStall = (state_d.mode != RCPM_RUN); // R07
        state_d.idle     = (state_d.mode == RCPM_IDLE); // R07
        state_d.pwdn     = (state_d.mode == RCPM_PD_PROT) ||
                           (state_d.mode == RCPM_PD_INTR); // R10
        state_d.clkStop  = state_d.pwdn; // R10
    end

    // State register; reset gives an empty image and run mode
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_q <= '{p0: RCPM_P0_RESET, mode: RCPM_RUN, default: '0};
        end else begin
            state_q <= state_d;
        end
    end

    // Config register: high-byte fields in the low byte only
    assign port0ConfigRegister = {8'h00, state_q.p0[15:8]}; // R02
    // Routed fields for clock, port 4 and port 6 logic
    assign clockConfigField    = state_q.p0[RCPM_CLK_LSB+:3]; // R03
    assign segmentAddrSelect   = state_q.p0[RCPM_SEG_LSB+:2]; // R03
    assign chipSelectCount     = state_q.p0[RCPM_CS_LSB+:2];  // R03
    assign writeConfigBit      = state_q.p0[RCPM_WRC_POS];    // R02
    // Bus config zero: both control bits follow external access
    assign busActiveZero       = state_q.eaLatched;            // R04
    assign latchStrobeCtlZero  = state_q.eaLatched;            // R04
    assign busWidthBits        = state_q.p0[RCPM_BUS_WIDTH_BITS_LSB+:2]; // R04
    // System config bits derived from the write config strap
    assign byteHighDisable     = state_q.byteDis;
    assign writeSignalConfig   = state_q.p0[RCPM_WRC_POS];
    // Internal straps
    assign bootloaderSelect    = state_q.p0[RCPM_BSL_POS];
    assign adaptModeBit        = state_q.p0[RCPM_ADP_POS];
    assign emulationMode       = state_q.p0[RCPM_EMU_POS];
    // Mode outputs, all registered
    assign cpuStall            = state_q.cpuStall;
    assign clkStop             = state_q.clkStop;
    assign idleActive          = state_q.idle;
    assign powerdownActive     = state_q.pwdn;
    assign lowPowerRefused     = state_q.refused; // R06
endmodule

// File: rcpm_top_tb_top.sv
// Purpose: self-checking bench for config latch and power modes
// Assumes: latch and mode changes settle within eight cycles
// Notes:   inputs change on the falling edge
`timescale 1ns/1ps
module rcpm_top_tb_top
    import rcpm_pkg::*;
;
    logic sys_clk, reset, resetSeqEnd, nmiPinN, busPending, readyEnabled;
    logic readySeenActive, intRequest, eventXferFail, powerdownConfigBit;
    logic externalAccessPin, resetInputPinN, wakeReset, refSeen;
    logic writeConfigBit, busActiveZero, latchStrobeCtlZero, byteHighDisable;
    logic writeSignalConfig, bootloaderSelect, adaptModeBit, emulationMode;
    logic cpuStall, clkStop, idleActive, powerdownActive, lowPowerRefused;
    logic [16:0] strap;
    logic [15:0] port0Pins, fastEdgeSel, port0ConfigRegister;
    logic [7:0]  fastExtIntPin;
    logic [2:0]  clockConfigField;
    logic [1:0]  lowPowerReq, segmentAddrSelect, chipSelectCount, busWidthBits;
    rcpm_rst_t   resetKind;
    int          n_fail, checks_done, cyc;

    rcpm_top u_dut (.*);
    rcpm_pins_model u_pins (.*);

    // Clock at 40 MHz
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // Refusal may be a pulse, so hold it until the next request
    always @(posedge sys_clk) begin
        if (lowPowerRefused) refSeen <= 1'b1;
        else if (lowPowerReq != 2'h0) refSeen <= 1'b0;
    end
    // Hang guard
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            end_of_test;
        end
    end
    task automatic chk(input string nm, input logic [15:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic w8;
        repeat (8) @(negedge sys_clk);
    endtask
    task automatic latch(input rcpm_rst_t k, input logic [16:0] s);
        strap = s;
        resetKind = k;
        w8;
        resetSeqEnd = 1'b1;
        @(negedge sys_clk);
        resetSeqEnd = 1'b0;
        w8;
    endtask
    task automatic vimg(input logic [15:0] im, input logic ea);
        chk("p0cfg", port0ConfigRegister, {8'h00, im[15:8]});
        chk("route", {clockConfigField, segmentAddrSelect, chipSelectCount},
            im[15:9]);
        chk("bus", {busActiveZero, latchStrobeCtlZero, busWidthBits},
            {ea, ea, im[7:6]});
        chk("low", {bootloaderSelect, adaptModeBit, emulationMode},
            {im[4], im[1:0]});
        chk("sys", {byteHighDisable, writeSignalConfig},
            {!im[8], im[8]});
    endtask
    // Every reset kind except RCPM_RST_NONE; soft kinds keep clock bits and clear 5..2
    task automatic t_latch;
        latch(RCPM_RST_LONG, 17'h1_a5d3);
        vimg(16'ha5d3, 1'b1);
        latch(RCPM_RST_SOFT, 17'h0_5a2c);
        vimg(16'hba03, 1'b0);
        latch(RCPM_RST_WDOG, 17'h1_ffff);
        vimg(16'hbfc3, 1'b1);
        latch(RCPM_RST_SHORT, 17'h0_0000);
        vimg(16'ha000, 1'b0);
        latch(RCPM_RST_POWER, 17'h1_3c99);
        vimg(16'h3c99, 1'b1);
    endtask
    task automatic lp(input logic [1:0] c, input logic [2:0] e);
        lowPowerReq = c;
        @(negedge sys_clk);
        lowPowerReq = 2'h0;
        w8;
        chk("mode", {idleActive, powerdownActive, refSeen}, e);
    endtask
    // Idle: drain, wake by interrupt and by failed transfer; ready refusal of a power-down request
    task automatic t_idle;
        busPending = 1'b1;
        lp(RCPM_REQ_IDLE, 3'b000);
        busPending = 1'b0;
        w8;
        chk("drained", idleActive, 1'b1);
        intRequest = 1'b1;
        @(negedge sys_clk);
        intRequest = 1'b0;
        w8;
        chk("int wake", idleActive, 1'b0);
        lp(RCPM_REQ_IDLE, 3'b100);
        eventXferFail = 1'b1;
        @(negedge sys_clk);
        eventXferFail = 1'b0;
        w8;
        chk("xfer wake", idleActive, 1'b0);
        readyEnabled = 1'b1;
        readySeenActive = 1'b0;
        lp(RCPM_REQ_PWDN, 3'b001);
        readyEnabled = 1'b0;
    endtask
    // Power-down: protected then interruptible
    task automatic t_pd;
        lp(RCPM_REQ_PWDN, 3'b001);
        nmiPinN = 1'b0;
        w8;
        lp(RCPM_REQ_PWDN, 3'b010);
        chk("clk stop", clkStop, 1'b1);
        fastEdgeSel = 16'h0001;
        fastExtIntPin = 8'h01;
        intRequest = 1'b1;
        w8;
        chk("prot hold", powerdownActive, 1'b1);
        intRequest = 1'b0;
        nmiPinN = 1'b1;
        wakeReset = 1'b1;
        w8;
        wakeReset = 1'b0;
        w8;
        chk("rst wake", powerdownActive, 1'b0);
        powerdownConfigBit = 1'b1;
        lp(RCPM_REQ_PWDN, 3'b001);
        fastExtIntPin = 8'h00;
        w8;
        lp(RCPM_REQ_PWDN, 3'b010);
        fastExtIntPin = 8'h01;
        w8;
        chk("pin wake", powerdownActive, 1'b0);
        chk("retained", port0ConfigRegister, 16'h003c);
    endtask
    task automatic end_of_test;
        if (n_fail == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        {resetSeqEnd, busPending, readyEnabled, intRequest} = 4'h0;
        {eventXferFail, powerdownConfigBit, wakeReset} = 3'h0;
        {nmiPinN, readySeenActive} = 2'h3;
        {strap, fastEdgeSel, fastExtIntPin, lowPowerReq} = '0;
        resetKind = RCPM_RST_NONE;
        reset = 1'b1;
        repeat (5) @(negedge sys_clk);
        reset = 1'b0;
        t_latch;
        t_idle;
        t_pd;
        end_of_test;
    end
endmodule
